/* design/isa_host_if.sv */
// isa i/o slave host interface: decode, strobes, nows, iochrdy, dma
//
// Behaviour
// - i/o accesses are decoded from sa[10:0] and only mapped windows answer.
// - sa[10] joins sa[9:3] in every window decode; only the extended ecp window needs it set.
// - a decoded read outside the ide window with the read strobe low drives the location on sd.
// - a decoded write outside the ide window stores sd at the rising edge of the write strobe.
// - nows is pulled low while a decoded access outside the ide window has a strobe asserted and iochrdy is released.
// - nows is never pulled for ide or dma cycles.
// - nows and iochrdy are open drain, only pulled low or released.
// - in epp mode iochrdy is pulled low during a strobed parallel window access while the parallel busy is high.
// - a strobe during the configuration period holds iochrdy low till it ends.
// - with aen high the cycle is not an i/o access, and is a dma transfer only with an acknowledge.
// - aen with an acknowledge makes the strobes a dma transfer.
// - reset drive returns every register to its default value.
// - while aen is high and an acknowledge is low the strobes act as dma strobes.
// - terminal count is honoured only while an acknowledge is low.
`timescale 1ns/1ns
module isa_host_if
    import isa_host_pkg::*;
#(
    parameter int unsigned CFG_COUNT = CFG_CYCLES
)
(
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire isa_host_pkg::isa_in_t  pins_in,
    output isa_host_pkg::isa_out_t      pins_out,
    output isa_host_pkg::func_sel_t     sel
);

    typedef struct packed {
        isa_in_t            s1;
        isa_in_t            s2;
        isa_in_t            s3;
        logic [CFG_CW-1:0]  cfg_cnt;
        logic               cfg_hold;
        logic               rd_v;
        isa_out_t           o;
        func_sel_t          f;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [7:0]        rdata;
    logic              we;
    logic [REG_AW-1:0] waddr;
    logic [REG_AW-1:0] raddr;
    logic              clear;

    // per function decode results
    logic       hit;
    logic [2:0] fn;
    logic       io_rd;
    logic       io_wr;
    logic       dma_f;
    logic       dma_p;
    logic       dma_any;
    logic       strobe;
    logic       wr_rise;
    logic       cfg_busy;

    always_comb
    begin
        s_d     = s_q;
        s_d.s1  = pins_in;
        s_d.s2  = s_q.s1;
        s_d.s3  = s_q.s2;
        hit     = 1'b0;
        fn      = FN_FDC;
        // mapped windows, ecp needs sa[10] set, others sa[10] clear
        if (s_q.s2.sa[10:WIN_BITS] == BASE_FDC[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_FDC;
        end
        else if (s_q.s2.sa[10:WIN_BITS] == BASE_SER_A[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_SER_A;
        end
        else if (s_q.s2.sa[10:WIN_BITS] == BASE_SER_B[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_SER_B;
        end
        else if (s_q.s2.sa[10:WIN_BITS] == BASE_PAR[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_PAR;
        end
        else if (s_q.s2.sa[10:WIN_BITS] == BASE_ECP[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_ECP;
        end
        else if (s_q.s2.sa[10:WIN_BITS] == BASE_IDE[10:WIN_BITS])
        begin
            hit = 1'b1;
            fn  = FN_IDE;
        end
        cfg_busy = (s_q.cfg_cnt != '0);
        strobe   = !s_q.s2.iorc_b || !s_q.s2.iowc_b;
        // address decode only counts with aen low
        io_rd    = hit && !s_q.s2.aen && !s_q.s2.iorc_b && !cfg_busy;
        io_wr    = hit && !s_q.s2.aen && !cfg_busy;
        // dma cycles: aen high with an acknowledge
        dma_f    = s_q.s2.aen && !s_q.s2.fdd_ack_b && !cfg_busy;
        dma_p    = s_q.s2.aen && !s_q.s2.pp_ack_b && s_q.s2.fdd_ack_b
                   && !cfg_busy;
        dma_any  = dma_f || dma_p;
        wr_rise  = s_q.s2.iowc_b && !s_q.s3.iowc_b;

        // configuration period countdown
        if (cfg_busy)
            s_d.cfg_cnt = s_q.cfg_cnt - 1'b1;
        if (cfg_busy && strobe)
            s_d.cfg_hold = 1'b1;
        else if (!cfg_busy)
            s_d.cfg_hold = 1'b0;

        // write at the rising edge, address and data of the same sample
        we    = 1'b0;
        waddr = {fn, s_q.s3.sa[WIN_BITS-1:0]};
        if (wr_rise && io_wr && (fn != FN_IDE))
            we = 1'b1;
        else if (wr_rise && dma_f)
        begin
            we    = 1'b1;
            waddr = {FN_FDC, DMA_OFS_FDC};
        end
        else if (wr_rise && dma_p)
        begin
            we    = 1'b1;
            waddr = {FN_ECP, DMA_OFS_ECP};
        end

        // read location
        if (dma_f)
            raddr = {FN_FDC, DMA_OFS_FDC};
        else if (dma_p)
            raddr = {FN_ECP, DMA_OFS_ECP};
        else
            raddr = {fn, s_q.s2.sa[WIN_BITS-1:0]};

        // data bus drive, one cycle after the read starts for fresh data
        s_d.rd_v       = (io_rd && (fn != FN_IDE))
                         || (dma_any && !s_q.s2.iorc_b);
        s_d.o.sd_out   = rdata;
        s_d.o.sd_oe    = s_d.rd_v && s_q.rd_v;

        // open drain pins: level fixed low, enable pulls
        s_d.o.nows_out    = 1'b0;
        s_d.o.iochrdy_out = 1'b0;
        s_d.o.nows_oe     = hit && !s_q.s2.aen && strobe && !cfg_busy
                            && (fn != FN_IDE);
        if (dma_any || s_q.s2.aen)
            s_d.o.nows_oe = 1'b0;
        s_d.o.iochrdy_oe  = s_d.cfg_hold
                            || (s_q.s2.epp_mode && s_q.s2.pp_busy
                                && hit && (fn == FN_PAR)
                                && !s_q.s2.aen && strobe);
        if (s_d.o.iochrdy_oe)
            s_d.o.nows_oe = 1'b0;

        // selects towards the inner functions
        s_d.f.fdc      = io_wr && strobe && (fn == FN_FDC);
        s_d.f.ser_a    = io_wr && strobe && (fn == FN_SER_A);
        s_d.f.ser_b    = io_wr && strobe && (fn == FN_SER_B);
        s_d.f.par      = io_wr && strobe && (fn == FN_PAR);
        s_d.f.ecp      = io_wr && strobe && (fn == FN_ECP);
        s_d.f.ide      = io_wr && strobe && (fn == FN_IDE);
        s_d.f.dma_fdc  = dma_f && strobe;
        s_d.f.dma_pp   = dma_p && strobe;
        s_d.f.tc_fdc   = s_q.s2.tc && dma_f;
        s_d.f.tc_pp    = s_q.s2.tc && dma_p;
        s_d.f.wr_pulse = we;
        s_d.f.ofs      = waddr[WIN_BITS-1:0];

        // reset drive pin returns the block to its defaults
        clear = s_q.s2.rst_drv;
        if (clear)
        begin
            s_d.cfg_cnt  = CFG_CW'(CFG_COUNT);
            s_d.cfg_hold = 1'b0;
            s_d.rd_v     = 1'b0;
            s_d.o        = '0;
            s_d.f        = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q          <= '0;
            s_q.s1       <= '1;
            s_q.s2       <= '1;
            s_q.s3       <= '1;
            s_q.cfg_cnt  <= CFG_CW'(CFG_COUNT);
        end
        else
            s_q <= s_d;
    end

    reg_store
    #(
        .WIDTH (8),
        .DEPTH (REG_DEPTH),
        .AW    (REG_AW),
        .INIT  (REG_RESET)
    )
    u_store
    (
        .clock (clock),
        .rst_b (rst_b),
        .clear (clear),
        .we    (we),
        .waddr (waddr),
        .wdata (s_q.s3.sd),
        .raddr (raddr),
        .rdata (rdata)
    );

    assign pins_out = s_q.o;
    assign sel      = s_q.f;

endmodule // isa_host_if

/* inc/isa_host_pkg.sv */
// constants and carrier types for the isa slave host interface
package isa_host_pkg;

    // function numbers, also the upper bits of the location index
    localparam logic [2:0] FN_FDC   = 3'h0;
    localparam logic [2:0] FN_SER_A = 3'h1;
    localparam logic [2:0] FN_SER_B = 3'h2;
    localparam logic [2:0] FN_PAR   = 3'h3;
    localparam logic [2:0] FN_ECP   = 3'h4;
    localparam logic [2:0] FN_IDE   = 3'h5;

    // base addresses on sa[10:0], each window is eight bytes
    localparam logic [10:0] BASE_FDC   = 11'h3f0;
    localparam logic [10:0] BASE_SER_A = 11'h3f8;
    localparam logic [10:0] BASE_SER_B = 11'h2f8;
    localparam logic [10:0] BASE_PAR   = 11'h378;
    localparam logic [10:0] BASE_ECP   = 11'h778;
    localparam logic [10:0] BASE_IDE   = 11'h1f0;

    // low address bits used inside a window
    localparam int unsigned WIN_BITS = 3;

    // location serviced by a dma cycle of each function
    localparam logic [2:0] DMA_OFS_FDC = 3'h5;
    localparam logic [2:0] DMA_OFS_ECP = 3'h0;

    // register storage shape and reset value
    localparam int unsigned REG_DEPTH = 40;
    localparam int unsigned REG_AW    = 6;
    localparam logic [7:0]  REG_RESET = 8'h00;

    // hardware configuration period after reset
    localparam int unsigned CLOCK_MHZ   = 125;
    localparam int unsigned CFG_TIME_US = 100;
    localparam int unsigned CFG_CYCLES  = CFG_TIME_US * CLOCK_MHZ;
    localparam int unsigned CFG_CW      = 24;

    // bus pins as sampled by the block
    typedef struct packed {
        logic [10:0] sa;
        logic [7:0]  sd;
        logic        iorc_b;
        logic        iowc_b;
        logic        aen;
        logic        fdd_ack_b;
        logic        pp_ack_b;
        logic        tc;
        logic        pp_busy;
        logic        epp_mode;
        logic        rst_drv;
    } isa_in_t;

    // bus pins driven by the block
    typedef struct packed {
        logic [7:0] sd_out;
        logic       sd_oe;
        logic       nows_out;
        logic       nows_oe;
        logic       iochrdy_out;
        logic       iochrdy_oe;
    } isa_out_t;

    // decoded selects towards the inner functions
    typedef struct packed {
        logic       fdc;
        logic       ser_a;
        logic       ser_b;
        logic       par;
        logic       ecp;
        logic       ide;
        logic       dma_fdc;
        logic       dma_pp;
        logic       tc_fdc;
        logic       tc_pp;
        logic       wr_pulse;
        logic [2:0] ofs;
    } func_sel_t;

endpackage

/* design/reg_store.sv */
// register storage with registered read data
`timescale 1ns/1ns
module reg_store
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 40,
    parameter int unsigned AW    = 6,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             clear,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } store_t;

    store_t s_q;
    store_t s_d;

    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (clear)
                s_d.mem[i] = INIT;
            else if (we && (waddr == AW'(i)))
                s_d.mem[i] = wdata;
        end
        s_d.rd = (raddr < AW'(DEPTH)) ? s_q.mem[raddr] : '0;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= {DEPTH + 1{INIT}};
        else
            s_q <= s_d;
    end

    assign rdata = s_q.rd;

endmodule // reg_store

/* testbench/isa_host_if_sva.sv */
// assertions on the isa slave host interface ports
`timescale 1ns/1ns
module isa_host_if_sva
    import isa_host_pkg::*;
#(
    parameter int unsigned CFG_COUNT = CFG_CYCLES
)
(
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire isa_host_pkg::isa_in_t   pins_in,
    input wire isa_host_pkg::isa_out_t  pins_out,
    input wire isa_host_pkg::func_sel_t sel
);
    logic [23:0] cyc_q;
    logic [23:0] cyc_d;
    logic        ready;
    logic        fdc_rd;
    logic        epp_rd;
    logic        idle;

    // cycles since reset or reset drive, saturating
    assign ready  = cyc_q > 24'(CFG_COUNT + 8);
    assign cyc_d  = pins_in.rst_drv ? '0 : (ready ? cyc_q : cyc_q + 24'h1);
    assign idle   = pins_in.iorc_b && pins_in.iowc_b;
    assign fdc_rd = !pins_in.iorc_b && !pins_in.aen && pins_in.sa == BASE_FDC;
    assign epp_rd = !pins_in.iorc_b && !pins_in.aen && pins_in.sa == BASE_PAR
                    && pins_in.epp_mode && pins_in.pp_busy;

    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            cyc_q <= '0;
        else
            cyc_q <= cyc_d;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_open_drain;
        !pins_out.nows_out && !pins_out.iochrdy_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin driven high");
    property p_nows_on;
        ready && $past(fdc_rd, 3) && $past(fdc_rd, 4) |-> pins_out.nows_oe;
    endproperty
    a_nows_on: assert property (p_nows_on)
        else $error("nows missing");
    property p_nows_off;
        $past(idle, 3) && $past(idle, 4) |-> !pins_out.nows_oe
                                             && !pins_out.sd_oe;
    endproperty
    a_nows_off: assert property (p_nows_off)
        else $error("output without strobe");
    property p_sd_read;
        pins_out.sd_oe |-> !$past(pins_in.iorc_b, 3);
    endproperty
    a_sd_read: assert property (p_sd_read)
        else $error("sd driven without read");
    property p_dma_nows;
        $past(pins_in.aen, 3) && $past(pins_in.aen, 4) |-> !pins_out.nows_oe;
    endproperty
    a_dma_nows: assert property (p_dma_nows)
        else $error("nows in dma cycle");
    property p_ide;
        sel.ide |-> !pins_out.nows_oe && !pins_out.sd_oe;
    endproperty
    a_ide: assert property (p_ide)
        else $error("ide access answered");
    property p_cfg_hold;
        cyc_q >= 24'h8 && cyc_q <= 24'(CFG_COUNT - 3)
            && !$past(pins_in.iorc_b, 4) |-> pins_out.iochrdy_oe;
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("iochrdy not held in config");
    property p_cfg_quiet;
        cyc_q <= 24'(CFG_COUNT) |-> !pins_out.nows_oe && !pins_out.sd_oe;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("access served in config");
    property p_tc;
        sel.tc_fdc |-> $past(pins_in.tc && !pins_in.fdd_ack_b, 3);
    endproperty
    a_tc: assert property (p_tc)
        else $error("tc without ack");
    property p_epp;
        $past(epp_rd, 3) && $past(epp_rd, 4) |-> pins_out.iochrdy_oe
                                                 && !pins_out.nows_oe;
    endproperty
    a_epp: assert property (p_epp)
        else $error("epp busy not stretched");
    property p_dma_sel;
        sel.dma_fdc || sel.dma_pp |-> $past(pins_in.aen, 3);
    endproperty
    a_dma_sel: assert property (p_dma_sel)
        else $error("dma strobe without aen");
endmodule // isa_host_if_sva

bind isa_host_if isa_host_if_sva #(.CFG_COUNT(CFG_COUNT)) u_sva
(
    .clock    (clock),
    .rst_b    (rst_b),
    .pins_in  (pins_in),
    .pins_out (pins_out),
    .sel      (sel)
);

/* testbench/isa_host_model.sv */
// host cpu and dma controller model on the isa pins
`timescale 1ns/1ns
module isa_host_model
    import isa_host_pkg::*;
(
    input  wire logic                    clock,
    input  wire isa_host_pkg::isa_out_t  pins_out,
    input  wire isa_host_pkg::func_sel_t sel,
    output isa_host_pkg::isa_in_t        pins_in
);
    logic       nows_q;
    logic       rdy_q;
    func_sel_t  seen_q;
    logic [2:0] ofs_q;

    // idle bus, data lines pulled up
    initial
        pins_in = isa_in_t'({11'h000, 8'hff, 2'h3, 1'h0, 2'h3, 4'h0});

    task automatic bus_cycle(
        input  logic        wr,
        input  logic [10:0] addr,
        input  logic [7:0]  data,
        input  logic        dma,
        input  logic        ack,
        input  int          len,
        output logic [7:0]  rdata
    );
        @(negedge clock);
        nows_q = 1'b0;
        rdy_q = 1'b0;
        seen_q = '0;
        ofs_q = 3'h7;
        pins_in.sa = addr;
        pins_in.aen = dma;
        pins_in.fdd_ack_b = !ack;
        pins_in.tc = ack || !pins_in.pp_ack_b;
        pins_in.sd = wr ? data : 8'hff;
        pins_in.iowc_b = !wr;
        pins_in.iorc_b = wr;
        for (int i = 0; i < len + 6; i++)
        begin
            @(negedge clock);
            nows_q |= pins_out.nows_oe;
            rdy_q |= pins_out.iochrdy_oe;
            seen_q |= sel;
            if (sel.wr_pulse)
                ofs_q = sel.ofs;
            if (i == len - 1)
                rdata = pins_out.sd_oe ? pins_out.sd_out : 8'hff;
            // data held one cycle past the write strobe edge
            if (i == len - 1)
                pins_in.iowc_b = 1'b1;
            if (i == len - 1)
                pins_in.iorc_b = 1'b1;
            if (i == len)
                pins_in = isa_in_t'({addr, 8'hff, 2'h3, 1'h0, 2'h3,
                                     pins_in[3:0]});
        end
    endtask
endmodule // isa_host_model

/* testbench/isa_host_if_tb.sv */
// self-checking bench for the isa slave host interface
`timescale 1ns/1ns
module isa_host_if_tb;
    import isa_host_pkg::*;
    localparam int unsigned CFG = 16;
    logic        clock;
    logic        rst_b;
    isa_in_t     pins_in;
    isa_out_t    pins_out;
    func_sel_t   sel;
    logic [7:0]  q;
    int          fails;
    int          tests_run;
    logic [10:0] addr [5] = '{11'h3f0, 11'h3f9, 11'h2fa, 11'h37b, 11'h77c};

    isa_host_if #(.CFG_COUNT(CFG)) dut
    (
        .clock    (clock),
        .rst_b    (rst_b),
        .pins_in  (pins_in),
        .pins_out (pins_out),
        .sel      (sel)
    );
    isa_host_model host
    (
        .clock    (clock),
        .pins_out (pins_out),
        .sel      (sel),
        .pins_in  (pins_in)
    );

    always #4 clock = ~clock;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cfg_hold;
        host.bus_cycle(1'b0, 11'h3f0, 8'h00, 1'b0, 1'b0, 6, q);
        check(q, 8'hff);
        check(8'(host.rdy_q), 8'h01);
        check(8'(host.nows_q), 8'h00);
        check(8'(host.seen_q[13:8]), 8'h00);
        repeat (CFG) @(negedge clock);
        check(8'(pins_out.iochrdy_oe), 8'h00);
    endtask

    task automatic rw_all;
        for (int i = 0; i < 5; i++)
        begin
            host.bus_cycle(1'b1, addr[i], 8'h5a + 8'(i), 1'b0, 1'b0, 4, q);
            check(8'(host.seen_q[13:8]), 8'(6'h20 >> i));
            check(8'(host.ofs_q), 8'(addr[i][2:0]));
        end
        for (int i = 0; i < 5; i++)
        begin
            host.bus_cycle(1'b0, addr[i], 8'h00, 1'b0, 1'b0, 5, q);
            check(q, 8'h5a + 8'(i));
            check(8'(host.nows_q), 8'h01);
        end
    endtask

    task automatic refused;
        host.bus_cycle(1'b1, 11'h7f0, 8'ha5, 1'b0, 1'b0, 4, q);
        check(8'({host.seen_q[13:8], host.seen_q[3]}), 8'h00);
        check(8'(host.nows_q), 8'h00);
        host.bus_cycle(1'b1, 11'h3f0, 8'ha5, 1'b1, 1'b0, 4, q);
        check(8'(host.nows_q), 8'h00);
        check(8'({host.seen_q[13:8], host.seen_q[3]}), 8'h00);
        host.bus_cycle(1'b0, 11'h1f0, 8'h00, 1'b0, 1'b0, 5, q);
        check(q, 8'hff);
        check(8'(host.nows_q), 8'h00);
        check(8'(host.seen_q[13:8]), 8'h01);
        host.bus_cycle(1'b0, 11'h3f0, 8'h00, 1'b0, 1'b0, 5, q);
        check(q, 8'h5a);
    endtask

    task automatic dma_write;
        host.bus_cycle(1'b1, 11'h000, 8'hc3, 1'b1, 1'b1, 4, q);
        check(8'(host.nows_q), 8'h00);
        check(8'(host.seen_q[7:3]), 8'h15);
        check(8'(host.ofs_q), 8'(DMA_OFS_FDC));
        host.bus_cycle(1'b0, 11'h3f5, 8'h00, 1'b0, 1'b0, 5, q);
        check(q, 8'hc3);
        host.bus_cycle(1'b0, 11'h000, 8'h00, 1'b1, 1'b1, 5, q);
        check(q, 8'hc3);
        check(8'(host.nows_q), 8'h00);
    endtask

    task automatic dma_par;
        @(negedge clock);
        host.pins_in.pp_ack_b = 1'b0;
        host.bus_cycle(1'b1, 11'h000, 8'h3c, 1'b1, 1'b0, 4, q);
        check(8'(host.seen_q[7:3]), 8'h0b);
        check(8'(host.ofs_q), 8'(DMA_OFS_ECP));
        host.bus_cycle(1'b0, 11'h778, 8'h00, 1'b0, 1'b0, 5, q);
        check(q, 8'h3c);
        check(8'(host.seen_q[13:8]), 8'h02);
    endtask

    task automatic epp_busy;
        @(negedge clock);
        host.pins_in.epp_mode = 1'b1;
        host.pins_in.pp_busy = 1'b1;
        host.bus_cycle(1'b0, 11'h378, 8'h00, 1'b0, 1'b0, 6, q);
        check(8'(host.rdy_q), 8'h01);
        check(8'(host.nows_q), 8'h00);
        host.pins_in.pp_busy = 1'b0;
        host.pins_in.epp_mode = 1'b0;
    endtask

    task automatic drive_reset;
        @(negedge clock);
        host.pins_in.rst_drv = 1'b1;
        repeat (4) @(negedge clock);
        host.pins_in.rst_drv = 1'b0;
        repeat (CFG + 8) @(negedge clock);
        host.bus_cycle(1'b0, 11'h3f9, 8'h00, 1'b0, 1'b0, 5, q);
        check(q, 8'h00);
    endtask

    initial
    begin
        clock = 1'b0;
        rst_b = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (4) @(negedge clock);
        check(pins_out.sd_out, 8'h00);
        check(8'(pins_out[4:0]), 8'h00);
        rst_b = 1'b1;
        cfg_hold;
        rw_all;
        refused;
        dma_write;
        dma_par;
        epp_busy;
        drive_reset;
        complete_run;
    end

    initial
    begin
        #400000;
        fails++;
        complete_run;
    end
endmodule // isa_host_if_tb
